// >>> verilog/hgc_global_ctrl.v
// hgc_global_ctrl.v: global control register group of the video hub
// assumes: AXI4-Lite master, strap and lock inputs synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
`include "hgc_regs.vh"
module hgc_global_ctrl #(
  parameter PORTS = 4,
  parameter [15:0] ROM_LOAD_CYCLES = `HGC_ROM_LOAD_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [6:0] strap_address,
  input wire [PORTS-1:0] rx_lock,
  input wire [PORTS-1:0] port_assigned,
  input wire [PORTS-1:0] parity_err_strobe,
  input wire refclk_detect,
  input wire [1:0] per_port_output_control,
  output reg [6:0] active_target_address,
  output reg logic_reset,
  output reg i2c_controller_en,
  output reg parity_check_en,
  output reg refclk_present,
  output reg [1:0] csi_output_state,
  output reg init_done,
  output reg [PORTS-1:0] parity_error_flag
);
  reg strap_taken;
  reg [6:0] strap_latch;
  reg [6:0] target_address_field;
  reg address_override_select;
  reg [7:0] general_cfg;
  reg [7:0] thold_hi;
  reg [7:0] thold_lo;
  reg rom_reload_trigger;
  reg [7:0] pulse_cnt;
  reg full_pending;
  reg aw_held;
  reg w_held;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [PORTS-1:0] flag_clear;
  wire regs_rst_n;
  wire write_go;
  wire [3:0] wr_idx;
  wire [3:0] rd_idx;
  wire wr_mapped;
  wire loader_busy;
  wire loader_done;
  wire [PORTS-1:0] err_flag_w;
  wire any_lock;
  wire [7:0] rst_addr_byte;
  reg [31:0] next_rdata;
  reg rd_ok;

  assign regs_rst_n = aresetn & ~(full_pending & pulse_cnt == 8'h01);
  assign write_go = (aw_held | s_axi_awvalid) & (w_held | s_axi_wvalid)
    & ~s_axi_bvalid;
  assign wr_idx = aw_held ? aw_addr[5:2] : s_axi_awaddr[5:2];
  assign rd_idx = s_axi_araddr[5:2];
  assign wr_mapped = (aw_held ? aw_addr[31:6] : s_axi_awaddr[31:6]) == 26'h0;
  assign any_lock = |(rx_lock & port_assigned);
  assign rst_addr_byte = `HGC_RST_TARGET_ADDR;

  // write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HGC_AXI_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (write_go && aw_held && w_held) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_mapped && (wr_idx == `HGC_IDX_TARGET_ADDR ||
          wr_idx == `HGC_IDX_SOFT_RESET || wr_idx == `HGC_IDX_GENERAL_CFG ||
          wr_idx == `HGC_IDX_PAR_THOLD_HI || wr_idx == `HGC_IDX_PAR_THOLD_LO))
          ? `HGC_AXI_OKAY : `HGC_AXI_SLVERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  wire do_write;
  assign do_write = aw_held & w_held & ~s_axi_bvalid & wr_mapped & w_strb[0];

  // strap capture after reset release
  always @(posedge aclk) begin
    if (!aresetn) begin
      strap_taken <= 1'b0;
      strap_latch <= 7'h00;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      strap_latch <= strap_address;
    end
  end

  // register file
  always @(posedge aclk) begin
    if (!regs_rst_n) begin
      target_address_field <= rst_addr_byte[`HGC_ADDR_MSB:`HGC_ADDR_LSB];
      address_override_select <= 1'b0;
      general_cfg <= `HGC_RST_GENERAL_CFG;
      thold_hi <= `HGC_RST_PAR_THOLD_HI;
      thold_lo <= `HGC_RST_PAR_THOLD_LO;
    end else begin
      if (!address_override_select)
        target_address_field <= strap_latch;
      if (do_write && wr_idx == `HGC_IDX_TARGET_ADDR) begin
        address_override_select <= w_data[`HGC_BIT_ADDR_OVERRIDE];
        if (w_data[`HGC_BIT_ADDR_OVERRIDE])
          target_address_field <= w_data[`HGC_ADDR_MSB:`HGC_ADDR_LSB];
      end
      if (do_write && wr_idx == `HGC_IDX_GENERAL_CFG)
        general_cfg <= w_data[7:0] & `HGC_CFG_WMASK;
      if (do_write && wr_idx == `HGC_IDX_PAR_THOLD_HI)
        thold_hi <= w_data[7:0];
      if (do_write && wr_idx == `HGC_IDX_PAR_THOLD_LO)
        thold_lo <= w_data[7:0];
    end
  end

  // soft reset sequencing
  always @(posedge aclk) begin
    if (!aresetn) begin
      rom_reload_trigger <= 1'b0;
      pulse_cnt <= 8'h00;
      full_pending <= 1'b0;
      logic_reset <= 1'b0;
    end else begin
      rom_reload_trigger <= do_write && wr_idx == `HGC_IDX_SOFT_RESET &&
        w_data[`HGC_BIT_ROM_RELOAD];
      if (do_write && wr_idx == `HGC_IDX_SOFT_RESET &&
          (w_data[`HGC_BIT_FULL_RESET] || w_data[`HGC_BIT_LOGIC_RESET])) begin
        pulse_cnt <= `HGC_RESET_PULSE_CYC;
        full_pending <= w_data[`HGC_BIT_FULL_RESET];
        logic_reset <= 1'b1;
      end else if (pulse_cnt != 8'h00) begin
        pulse_cnt <= pulse_cnt - 8'h01;
        if (pulse_cnt == 8'h01) begin
          logic_reset <= 1'b0;
          full_pending <= 1'b0;
        end
      end
    end
  end

  hgc_rom_loader #(
    .LOAD_CYCLES(ROM_LOAD_CYCLES)
  ) u_loader (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(rom_reload_trigger),
    .busy(loader_busy),
    .done(loader_done)
  );

  hgc_parity_mon #(
    .PORTS(PORTS)
  ) u_parity (
    .aclk(aclk),
    .aresetn(aresetn & ~logic_reset),
    .enable(general_cfg[`HGC_BIT_PARITY_EN]),
    .threshold({thold_hi, thold_lo}),
    .err_strobe(parity_err_strobe),
    .flag_clear(flag_clear),
    .err_flag(err_flag_w)
  );

  // read data mux
  always @* begin
    next_rdata = 32'h0000_0000;
    rd_ok = s_axi_araddr[31:6] == 26'h0;
    case (rd_idx)
      `HGC_IDX_TARGET_ADDR:
        next_rdata[7:0] = {target_address_field, address_override_select};
      `HGC_IDX_SOFT_RESET:
        next_rdata[7:0] = {5'h00, rom_reload_trigger | loader_busy & 1'b0,
          full_pending, logic_reset & ~full_pending};
      `HGC_IDX_GENERAL_CFG:
        next_rdata[7:0] = general_cfg;
      `HGC_IDX_DEVICE_STATUS:
        next_rdata[7:0] = {1'b0, init_done, 1'b0, refclk_present, 4'h0};
      `HGC_IDX_PAR_THOLD_HI:
        next_rdata[7:0] = thold_hi;
      `HGC_IDX_PAR_THOLD_LO:
        next_rdata[7:0] = thold_lo;
      `HGC_IDX_LOCK_STATUS:
        next_rdata[PORTS-1:0] = parity_error_flag;
      default:
        rd_ok = 1'b0;
    endcase
  end

  // read channel, parity flags clear on read
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `HGC_AXI_OKAY;
      flag_clear <= {PORTS{1'b0}};
    end else begin
      flag_clear <= {PORTS{1'b0}};
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? next_rdata : 32'h0000_0000;
        s_axi_rresp <= rd_ok ? `HGC_AXI_OKAY : `HGC_AXI_SLVERR;
        if (rd_ok && rd_idx == `HGC_IDX_LOCK_STATUS)
          flag_clear <= parity_error_flag & ~err_flag_w | parity_error_flag;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // outputs to the rest of the device
  always @(posedge aclk) begin
    if (!aresetn) begin
      active_target_address <= 7'h00;
      i2c_controller_en <= 1'b0;
      parity_check_en <= 1'b1;
      refclk_present <= 1'b0;
      csi_output_state <= `HGC_CSI_HIZ;
      init_done <= 1'b0;
      parity_error_flag <= {PORTS{1'b0}};
    end else begin
      active_target_address <= address_override_select ?
        target_address_field : strap_latch;
      i2c_controller_en <= general_cfg[`HGC_BIT_I2C_CTRL_EN];
      parity_check_en <= general_cfg[`HGC_BIT_PARITY_EN];
      refclk_present <= general_cfg[`HGC_BIT_REFCLK_FORCE] | refclk_detect;
      init_done <= loader_done & ~rom_reload_trigger;
      parity_error_flag <= err_flag_w;
      if (general_cfg[`HGC_BIT_SLEEP_STATE] &&
          !general_cfg[`HGC_BIT_OUTPUT_EN])
        csi_output_state <= `HGC_CSI_HIZ;
      else if (!general_cfg[`HGC_BIT_SLEEP_STATE] && !any_lock)
        csi_output_state <= `HGC_CSI_HS0;
      else if (!general_cfg[`HGC_BIT_OUT_EN_MODE] && !any_lock)
        csi_output_state <= `HGC_CSI_HIZ;
      else if (!any_lock)
        csi_output_state <= `HGC_CSI_LP11;
      else
        csi_output_state <= per_port_output_control;
    end
  end
endmodule // hgc_global_ctrl
`default_nettype wire

// >>> shared/hgc_regs.vh
// hgc_regs.vh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the hub control design files
`ifndef HGC_REGS_VH
`define HGC_REGS_VH

// printed offsets are indices; byte address is four times the index
`define HGC_IDX_TARGET_ADDR 4'h0
`define HGC_IDX_SOFT_RESET 4'h1
`define HGC_IDX_GENERAL_CFG 4'h2
`define HGC_IDX_DEVICE_STATUS 4'h4
`define HGC_IDX_PAR_THOLD_HI 4'h5
`define HGC_IDX_PAR_THOLD_LO 4'h6
`define HGC_IDX_LOCK_STATUS 4'h9

`define HGC_RST_TARGET_ADDR 8'h00
`define HGC_RST_SOFT_RESET 8'h00
`define HGC_RST_GENERAL_CFG 8'h1e
`define HGC_RST_PAR_THOLD_HI 8'h01
`define HGC_RST_PAR_THOLD_LO 8'h00

// target address register fields
`define HGC_BIT_ADDR_OVERRIDE 0
`define HGC_ADDR_MSB 7
`define HGC_ADDR_LSB 1

// soft reset register fields
`define HGC_BIT_LOGIC_RESET 0
`define HGC_BIT_FULL_RESET 1
`define HGC_BIT_ROM_RELOAD 2

// general configuration fields
`define HGC_BIT_REFCLK_FORCE 0
`define HGC_BIT_PARITY_EN 1
`define HGC_BIT_SLEEP_STATE 2
`define HGC_BIT_OUTPUT_EN 3
`define HGC_BIT_OUT_EN_MODE 4
`define HGC_BIT_I2C_CTRL_EN 5
`define HGC_CFG_WMASK 8'h3f

// device status fields
`define HGC_BIT_INIT_DONE 6
`define HGC_BIT_REFCLK_VALID 4

// csi output states
`define HGC_CSI_NORMAL 2'h0
`define HGC_CSI_HIZ 2'h1
`define HGC_CSI_HS0 2'h2
`define HGC_CSI_LP11 2'h3

// timing
`define HGC_RESET_PULSE_NS 80
`define HGC_CLK_PERIOD_NS 10
`define HGC_RESET_PULSE_CYC 8'h08
`define HGC_ROM_LOAD_CYC 16'h0040

`define HGC_AXI_OKAY 2'h0
`define HGC_AXI_SLVERR 2'h2

`endif

// >>> verilog/hgc_rom_loader.v
// hgc_rom_loader.v: models the configuration load sequencer timing
// assumes: start pulse from the register block, same clock and reset
`timescale 1ns/1ps
`default_nettype none
`include "hgc_regs.vh"
module hgc_rom_loader #(
  parameter [15:0] LOAD_CYCLES = `HGC_ROM_LOAD_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire start,
  output reg busy,
  output reg done
);
  reg [15:0] count;
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b1;
      done <= 1'b0;
      count <= 16'h0000;
    end else if (start) begin
      busy <= 1'b1;
      done <= 1'b0;
      count <= 16'h0000;
    end else if (busy) begin
      if (count == LOAD_CYCLES - 16'h0001) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule // hgc_rom_loader
`default_nettype wire

// >>> verilog/hgc_parity_mon.v
// hgc_parity_mon.v: per-port parity error counters against a threshold
// assumes: error strobes are one-cycle pulses synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module hgc_parity_mon #(
  parameter PORTS = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire enable,
  input wire [15:0] threshold,
  input wire [PORTS-1:0] err_strobe,
  input wire [PORTS-1:0] flag_clear,
  output reg [PORTS-1:0] err_flag
);
  genvar i;
  generate
    for (i = 0; i < PORTS; i = i + 1) begin : g_port
      reg [15:0] cnt;
      wire hit;
      wire [15:0] next_cnt;
      assign hit = enable & err_strobe[i];
      assign next_cnt = (hit && cnt != 16'hffff) ? cnt + 16'h0001 : cnt;
      always @(posedge aclk) begin
        if (!aresetn) begin
          cnt <= 16'h0000;
          err_flag[i] <= 1'b0;
        end else begin
          cnt <= flag_clear[i] ? 16'h0000 : next_cnt;
          if (enable && next_cnt >= threshold && hit)
            err_flag[i] <= 1'b1;
          else if (flag_clear[i])
            err_flag[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // hgc_parity_mon
`default_nettype wire

// >>> testbench/hgc_ctrl_monitor.sv
// hgc_ctrl_monitor.sv: port checker for the hub global control block
// assumes: bound to hgc_global_ctrl, one clock aclk
`timescale 1ns/1ps
`default_nettype none
`include "hgc_regs.vh"
module hgc_ctrl_monitor #(
  parameter PORTS = 4,
  parameter [15:0] ROM_LOAD_CYCLES = 16'h0040
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PORTS-1:0] rx_lock,
  input wire logic [PORTS-1:0] port_assigned,
  input wire logic [PORTS-1:0] parity_err_strobe,
  input wire logic refclk_detect,
  input wire logic refclk_present,
  input wire logic logic_reset,
  input wire logic parity_check_en,
  input wire logic [1:0] csi_output_state,
  input wire logic init_done,
  input wire logic [PORTS-1:0] parity_error_flag
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire logic lost;
  assign lost = ~|(rx_lock & port_assigned);
  AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("aw ready while response pending");
  AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read answered twice");
  AST_REFCLK: assert property (
    refclk_detect |=> refclk_present) else $error("refclk not shown");
  AST_PULSE_LEN: assert property (
    $rose(logic_reset) |-> logic_reset[*8] ##1 !logic_reset)
    else $error("reset pulse length");
  AST_CSI_UNLOCKED: assert property (
    lost ##1 lost |-> csi_output_state != `HGC_CSI_NORMAL)
    else $error("csi normal while unlocked");
  AST_INIT_DONE: assert property (
    $rose(aresetn) |-> !init_done ##[1:300] init_done)
    else $error("init not done");
  AST_PAR_CAUSE: assert property (
    $rose(parity_error_flag[0]) |-> $past(parity_err_strobe[0]) ||
    $past(parity_err_strobe[0], 2)) else $error("flag without error");
  AST_PAR_OFF: assert property (
    !parity_check_en [*3] |-> !$rose(parity_error_flag[0]))
    else $error("flag while check off");
endmodule // hgc_ctrl_monitor
bind hgc_global_ctrl hgc_ctrl_monitor #(.PORTS(PORTS),
  .ROM_LOAD_CYCLES(ROM_LOAD_CYCLES)) mon (.*);
`default_nettype wire

// >>> testbench/hgc_host_model.sv
// hgc_host_model.sv: configuration software as an AXI4-Lite master
// assumes: shares aclk with the slave, one access at a time
`timescale 1ns/1ps
`default_nettype none
module hgc_host_model (
  input wire logic aclk,
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [31:0] a, v, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        done = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  task automatic poll_init;
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h0000_0000;
    while (!d[6])
      rd(32'h0000_0010, d, r);
  endtask
endmodule // hgc_host_model
`default_nettype wire

// >>> testbench/hgc_testbench.sv
// hgc_testbench.sv: directed register tests of the hub global control block
// assumes: host model drives the bus, bench drives the side inputs
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, refclk_detect;
  logic logic_reset, i2c_controller_en, parity_check_en, refclk_present;
  logic init_done;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, rx_lock, port_assigned, parity_err_strobe;
  logic [3:0] parity_error_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp, per_port_output_control, r;
  logic [1:0] csi_output_state;
  logic [6:0] strap_address, active_target_address;
  logic [10:0] tl [6] = '{11'h025, 11'h006, 11'h002, 11'h061, 11'h0e3,
    11'h0e6};
  int err_count, check_count, cyc;
  hgc_global_ctrl #(.PORTS(4), .ROM_LOAD_CYCLES(16'h0004)) uut (.*);
  hgc_host_model host (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      wrap_up;
    end
  end
  task wrap_up;
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, e);
    #1;
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task rdc(input logic [7:0] a, e);
    host.rd({24'h00_0000, a}, d, r);
    chk(d, {24'h00_0000, e});
  endtask
  task wrc(input logic [7:0] a, v);
    host.wr({24'h00_0000, a}, {24'h00_0000, v}, r);
    chk(r, 2'h0);
  endtask
  task burst(input int n);
    repeat (n) begin
      @(posedge aclk);
      parity_err_strobe <= 4'h1;
      @(posedge aclk);
      parity_err_strobe <= 4'h0;
    end
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask
  initial begin
    aresetn = 1'b0;
    refclk_detect = 1'b0;
    rx_lock = 4'hf;
    port_assigned = 4'hf;
    parity_err_strobe = 4'h0;
    per_port_output_control = 2'h2;
    strap_address = 7'h2a;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    host.poll_init;
    rdc(8'h00, 8'h54);
    rdc(8'h04, 8'h00);
    rdc(8'h08, 8'h1e);
    rdc(8'h10, 8'h40);
    chk({i2c_controller_en, parity_check_en}, 2'h1);
    wrc(8'h00, 8'h7e);
    rdc(8'h00, 8'h54);
    chk(active_target_address, 7'h2a);
    wrc(8'h00, 8'h7f);
    rdc(8'h00, 8'h7f);
    chk(active_target_address, 7'h3f);
    wrc(8'h08, 8'hff);
    rdc(8'h08, 8'h3f);
    chk({i2c_controller_en, refclk_present}, 2'h3);
    wrc(8'h04, 8'hf8);
    rdc(8'h04, 8'h00);
    rdc(8'h10, 8'h50);
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      rx_lock <= {4{tl[i][2]}};
      wrc(8'h08, tl[i][10:3]);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk(csi_output_state, tl[i][1:0]);
    end
    wrc(8'h08, 8'h1e);
    wrc(8'h14, 8'h00);
    wrc(8'h18, 8'h03);
    burst(2);
    chk(parity_error_flag, 4'h0);
    burst(1);
    chk(parity_error_flag, 4'h1);
    rdc(8'h24, 8'h01);
    rdc(8'h24, 8'h00);
    wrc(8'h08, 8'h1c);
    burst(1);
    chk(parity_error_flag, 4'h0);
    @(posedge aclk);
    refclk_detect <= 1'b1;
    rdc(8'h10, 8'h50);
    wrc(8'h08, 8'h3c);
    wrc(8'h04, 8'h01);
    repeat (10) @(posedge aclk);
    rdc(8'h04, 8'h00);
    rdc(8'h08, 8'h3c);
    wrc(8'h04, 8'h02);
    repeat (10) @(posedge aclk);
    rdc(8'h04, 8'h00);
    rdc(8'h08, 8'h1e);
    rdc(8'h00, 8'h54);
    chk(active_target_address, 7'h2a);
    wrc(8'h04, 8'h04);
    host.poll_init;
    rdc(8'h04, 8'h00);
    chk(init_done, 1'b1);
    host.rd(32'h0000_000c, d, r);
    chk({r, d[7:0]}, 10'h200);
    host.wr(32'h0000_000c, 32'h0000_0001, r);
    chk(r, 2'h2);
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
